//--- pie_consts.vh
`ifndef PIE_CONSTS_VH
`define PIE_CONSTS_VH
// ****************************************************************
// Register map
// ****************************************************************
`define PIE_ADDR_W 2
`define PIE_OFS_EDGE 2'h0
`define PIE_OFS_CTL0 2'h1
`define PIE_OFS_CTL1 2'h2
`define PIE_OFS_MASK 2'h3
`define PIE_RST_EDGE 8'h00
`define PIE_RST_CTL0 8'h00
`define PIE_RST_CTL1 8'h00
`define PIE_RST_MASK 8'h00
`define PIE_EDGE_IMPL 8'h0F
`define PIE_CTL0_IMPL 8'h7F
// ****************************************************************
// Field positions
// ****************************************************************
`define PIE_B_EDGE_HI 3
`define PIE_B_EDGE_LO 2
`define PIE_A_EDGE_HI 1
`define PIE_A_EDGE_LO 0
`define PIE_SER_F 6
`define PIE_PINB_F 5
`define PIE_PINA_F 4
`define PIE_SER_E 3
`define PIE_PINB_E 2
`define PIE_PINA_E 1
`define PIE_EMI 0
`define PIE_TB_F 7
`define PIE_TK2_F 6
`define PIE_TK1_F 5
`define PIE_TK0_F 4
`define PIE_TB_E 3
`define PIE_TK2_E 2
`define PIE_TK1_E 1
`define PIE_TK0_E 0
// Edge select encodings.
`define PIE_EDGE_OFF 2'h0
`define PIE_EDGE_RISE 2'h1
`define PIE_EDGE_FALL 2'h2
`define PIE_EDGE_BOTH 2'h3
`endif

//--- pie_sync.v
`default_nettype none
// ****************************************************************
// Two-stage synchroniser for one pin
// ****************************************************************
module pie_sync (
  input wire clk,
  input wire reset,
  input wire pin_in,
  output reg pin_sync
);
  reg meta_reg;

  // First stage feeds only the second stage.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule // pie_sync
`default_nettype wire

//--- pie_edge_det.v
`default_nettype none
`include "pie_consts.vh"
// ****************************************************************
// Selectable edge detector for one synchronised pin
// ****************************************************************
module pie_edge_det (
  input wire clk,
  input wire reset,
  input wire pin_sync,
  input wire [1:0] edge_sel,
  output wire hit
);
  reg prev_reg;
  wire rise;
  wire fall;

  // Previous level resets low, matching the idle pin, so a quiet pin
  // shows no edge after reset; a pin already high shows one rise.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_sync;
    end
  end

  assign rise = pin_sync & ~prev_reg;
  assign fall = ~pin_sync & prev_reg;
  // Encoding decode shared by both pins.
  assign hit = ((edge_sel == `PIE_EDGE_RISE) & rise) |
               ((edge_sel == `PIE_EDGE_FALL) & fall) |
               ((edge_sel == `PIE_EDGE_BOTH) & (rise | fall));
endmodule // pie_edge_det
`default_nettype wire

//--- pie_irq_ctrl.v
// Implementation choices: the register addresses and the address-and-strobe port.
`default_nettype none
`include "pie_consts.vh"
// ****************************************************************
// Primary interrupt control: edge select, flags, enables
// ****************************************************************
module pie_irq_ctrl (
  input wire clk,
  input wire reset,
  input wire [1:0] addr,
  input wire [7:0] wr_data,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rd_data,
  input wire ext_irq_pin_a,
  input wire ext_irq_pin_b,
  input wire serial_module_evt,
  input wire time_base_a_evt,
  input wire [2:0] touch_unit_evt,
  output reg cpu_irq_req,
  output reg irq_out
);
  reg [7:0] edge_reg;
  reg [7:0] ctl0_reg;
  reg [7:0] ctl1_reg;
  reg [7:0] mask_reg;
  reg [7:0] ctl0_next;
  reg [7:0] ctl1_next;
  reg [7:0] rd_next;
  wire pin_a_sync;
  wire pin_b_sync;
  wire pin_a_hit;
  wire pin_b_hit;
  wire wr_edge;
  wire wr_ctl0;
  wire wr_ctl1;
  wire wr_mask;
  wire [7:0] status;
  wire any_req;

  // ****************************************************************
  // Pin synchronisers and edge detectors
  // ****************************************************************
  pie_sync u_sync_a (
    .clk(clk),
    .reset(reset),
    .pin_in(ext_irq_pin_a),
    .pin_sync(pin_a_sync)
  );

  pie_sync u_sync_b (
    .clk(clk),
    .reset(reset),
    .pin_in(ext_irq_pin_b),
    .pin_sync(pin_b_sync)
  );

  // Pin A uses bits 1:0 of the edge register.
  pie_edge_det u_edge_a (
    .clk(clk),
    .reset(reset),
    .pin_sync(pin_a_sync),
    .edge_sel(edge_reg[`PIE_A_EDGE_HI:`PIE_A_EDGE_LO]),
    .hit(pin_a_hit)
  );

  // Pin B uses bits 3:2 of the edge register.
  pie_edge_det u_edge_b (
    .clk(clk),
    .reset(reset),
    .pin_sync(pin_b_sync),
    .edge_sel(edge_reg[`PIE_B_EDGE_HI:`PIE_B_EDGE_LO]),
    .hit(pin_b_hit)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign wr_edge = wr_stb & (addr == `PIE_OFS_EDGE);
  assign wr_ctl0 = wr_stb & (addr == `PIE_OFS_CTL0);
  assign wr_ctl1 = wr_stb & (addr == `PIE_OFS_CTL1);
  assign wr_mask = wr_stb & (addr == `PIE_OFS_MASK);

  // Only the four edge bits store; the upper bits stay zero.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      edge_reg <= `PIE_RST_EDGE;
    end else if (wr_edge) begin
      edge_reg <= wr_data & `PIE_EDGE_IMPL;
    end
  end

  // ****************************************************************
  // First control register
  // ****************************************************************
  // Software writes bits 6:0, so a written 0 clears a flag; a
  // hardware event in the same cycle still sets it, so no event is lost.
  always @* begin
    ctl0_next = ctl0_reg;
    if (wr_ctl0) begin
      ctl0_next = wr_data & `PIE_CTL0_IMPL;
    end
    if (serial_module_evt) begin
      ctl0_next[`PIE_SER_F] = 1'b1;
    end
    if (pin_b_hit) begin
      ctl0_next[`PIE_PINB_F] = 1'b1;
    end
    if (pin_a_hit) begin
      ctl0_next[`PIE_PINA_F] = 1'b1;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl0_reg <= `PIE_RST_CTL0;
    end else begin
      ctl0_reg <= ctl0_next;
    end
  end

  // ****************************************************************
  // Second control register
  // ****************************************************************
  // Same set-wins-over-clear policy as the first register.
  always @* begin
    ctl1_next = ctl1_reg;
    if (wr_ctl1) begin
      ctl1_next = wr_data;
    end
    if (time_base_a_evt) begin
      ctl1_next[`PIE_TB_F] = 1'b1;
    end
    if (touch_unit_evt[2]) begin
      ctl1_next[`PIE_TK2_F] = 1'b1;
    end
    if (touch_unit_evt[1]) begin
      ctl1_next[`PIE_TK1_F] = 1'b1;
    end
    if (touch_unit_evt[0]) begin
      ctl1_next[`PIE_TK0_F] = 1'b1;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl1_reg <= `PIE_RST_CTL1;
    end else begin
      ctl1_reg <= ctl1_next;
    end
  end

  // Mask register gating the summary interrupt line.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_reg <= `PIE_RST_MASK;
    end else if (wr_mask) begin
      mask_reg <= wr_data;
    end
  end

  // ****************************************************************
  // Request to the core and summary interrupt
  // ****************************************************************
  // Each flag pairs with its own enable; the master enable gates the core request only.
  assign any_req =
    (ctl0_reg[`PIE_SER_F] & ctl0_reg[`PIE_SER_E]) |
    (ctl0_reg[`PIE_PINB_F] & ctl0_reg[`PIE_PINB_E]) |
    (ctl0_reg[`PIE_PINA_F] & ctl0_reg[`PIE_PINA_E]) |
    (ctl1_reg[`PIE_TB_F] & ctl1_reg[`PIE_TB_E]) |
    (ctl1_reg[`PIE_TK2_F] & ctl1_reg[`PIE_TK2_E]) |
    (ctl1_reg[`PIE_TK1_F] & ctl1_reg[`PIE_TK1_E]) |
    (ctl1_reg[`PIE_TK0_F] & ctl1_reg[`PIE_TK0_E]);

  // Status view: the seven hardware flags packed into one byte.
  assign status = {1'b0, ctl1_reg[`PIE_TB_F], ctl1_reg[`PIE_TK2_F],
                   ctl1_reg[`PIE_TK1_F], ctl1_reg[`PIE_TK0_F],
                   ctl0_reg[`PIE_SER_F], ctl0_reg[`PIE_PINB_F],
                   ctl0_reg[`PIE_PINA_F]};

  // Outputs are registered, so they lag the flags by one cycle.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_irq_req <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      cpu_irq_req <= any_req & ctl0_reg[`PIE_EMI];
      irq_out <= |(status & mask_reg);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always @* begin
    if (addr == `PIE_OFS_EDGE) begin
      rd_next = edge_reg;
    end else if (addr == `PIE_OFS_CTL0) begin
      rd_next = ctl0_reg;
    end else if (addr == `PIE_OFS_CTL1) begin
      rd_next = ctl1_reg;
    end else begin
      rd_next = mask_reg;
    end
  end

  // Read data valid only in the cycle after the strobe, zero otherwise.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (rd_stb) begin
      rd_data <= rd_next;
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule // pie_irq_ctrl
`default_nettype wire

//--- pie_irq_props.sv
`default_nettype none
// ****************************************************************
// Port checker for the interrupt control block
// ****************************************************************
module pie_irq_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic serial_module_evt,
  input wire logic [2:0] touch_unit_evt,
  input wire logic cpu_irq_req,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_reg [4];

  // Last written values; hardware-set flags are not tracked, so only the
  // enable and select bits of these shadows are trusted.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sh_reg <= '{default: 8'h00};
    end else if (wr_stb) begin
      sh_reg[addr] <= wr_data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  rd_idle_a: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
    else $error("read data not idle");
  edge_top_a: assert property (
    $past(rd_stb) && $past(addr) == 2'h0 |-> rd_data[7:4] == 4'h0)
    else $error("edge register top bits set");
  ser_flag_a: assert property (
    serial_module_evt ##[1:4] (rd_stb && addr == 2'h1) |=> rd_data[6])
    else $error("serial flag not set");
  tk_flag_a: assert property (
    touch_unit_evt == 3'h7 ##[1:4] (rd_stb && addr == 2'h2)
    |=> rd_data[6:4] == 3'h7) else $error("touch flags not set");
  master_off_a: assert property (
    !sh_reg[1][0] && !$past(sh_reg[1][0]) |-> !cpu_irq_req)
    else $error("request with master enable off");
  mask_off_a: assert property (
    sh_reg[3] == 8'h00 && $past(sh_reg[3]) == 8'h00 |-> !irq_out)
    else $error("interrupt with all masked");
  pin_a_rise_a: assert property (
    $rose(ext_irq_pin_a) && sh_reg[0][1:0] == 2'h1
    && sh_reg[1][1:0] == 2'h3 |-> ##[2:6] cpu_irq_req)
    else $error("pin A rise lost");
  pin_b_fall_a: assert property (
    $fell(ext_irq_pin_b) && sh_reg[0][3:2] == 2'h2
    && sh_reg[1][2] && sh_reg[1][0] |-> ##[2:6] cpu_irq_req)
    else $error("pin B fall lost");
endmodule // pie_irq_props

bind pie_irq_ctrl pie_irq_props pie_irq_props_i (.*);
`default_nettype wire

//--- pie_src_model.sv
`default_nettype none
// ****************************************************************
// Interrupt sources on the far side
// ****************************************************************
module pie_src_model (
  input wire logic clk,
  output logic ext_irq_pin_a,
  output logic ext_irq_pin_b,
  output logic serial_module_evt,
  output logic time_base_a_evt,
  output logic [2:0] touch_unit_evt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins idle low and events stay quiet until commanded.
  initial begin
    {ext_irq_pin_a, ext_irq_pin_b} = 2'h0;
    {serial_module_evt, time_base_a_evt, touch_unit_evt} = 5'h00;
  end
  task automatic set_pins(input logic a, input logic b);
    @(posedge clk);
    ext_irq_pin_a <= a;
    ext_irq_pin_b <= b;
  endtask
  // Events are one-cycle pulses; a held line would set flags again.
  task automatic pulse(input logic [4:0] ev);
    @(posedge clk);
    {serial_module_evt, time_base_a_evt, touch_unit_evt} <= ev;
    @(posedge clk);
    {serial_module_evt, time_base_a_evt, touch_unit_evt} <= 5'h00;
  endtask
endmodule // pie_src_model
`default_nettype wire

//--- testbench.sv
`default_nettype none
// ****************************************************************
// Self-checking bench for the interrupt control block
// ****************************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, wr_stb, rd_stb, cpu_irq_req, irq_out;
  logic ext_irq_pin_a, ext_irq_pin_b, serial_module_evt, time_base_a_evt;
  logic [1:0] addr;
  logic [2:0] touch_unit_evt;
  logic [7:0] wr_data, rd_data;
  int fail_count = 0;
  int n_tests = 0;
  pie_irq_ctrl pie_irq_ctrl_i (.*);
  pie_src_model pie_src_model_i (.*);

  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Reset values, then the edge and both control registers written full and read back.
  task automatic t_access;
    for (int i = 0; i < 4; i++) rd(i[1:0], 8'h00);
    wr(2'h0, 8'hFF);
    rd(2'h0, 8'h0F);
    wr(2'h1, 8'hFF);
    rd(2'h1, 8'h7F);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'hFF);
    for (int i = 0; i < 4; i++) wr(i[1:0], 8'h00);
  endtask
  task automatic t_events;
    pie_src_model_i.pulse(5'h1F);
    rd(2'h1, 8'h40);
    rd(2'h2, 8'hF0);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h00);
  endtask
  // Every edge code on both pins: rise, then fall.
  task automatic t_edges;
    for (int c = 0; c < 4; c++) begin
      wr(2'h0, {4'h0, c[1:0], c[1:0]});
      pie_src_model_i.set_pins(1'b1, 1'b1);
      cyc(5);
      rd(2'h1, {2'h0, {2{c[0]}}, 4'h0});
      wr(2'h1, 8'h00);
      pie_src_model_i.set_pins(1'b0, 1'b0);
      cyc(5);
      rd(2'h1, {2'h0, {2{c[1]}}, 4'h0});
      wr(2'h1, 8'h00);
    end
  endtask
  task automatic t_irq;
    wr(2'h1, 8'h08);
    pie_src_model_i.pulse(5'h10);
    cyc(3);
    chk({7'h00, cpu_irq_req}, 8'h00);
    wr(2'h1, 8'h49);
    cyc(2);
    chk({7'h00, cpu_irq_req}, 8'h01);
    wr(2'h3, 8'h04);
    cyc(2);
    chk({7'h00, irq_out}, 8'h01);
    wr(2'h3, 8'h00);
    wr(2'h1, 8'h01);
    wr(2'h2, 8'h11);
    cyc(2);
    chk({6'h00, irq_out, cpu_irq_req}, 8'h01);
    wr(2'h2, 8'h10);
    cyc(2);
    chk({7'h00, cpu_irq_req}, 8'h00);
    wr(2'h0, 8'h09);
    wr(2'h1, 8'h07);
    pie_src_model_i.set_pins(1'b1, 1'b1);
    cyc(6);
    chk({7'h00, cpu_irq_req}, 8'h01);
    rd(2'h1, 8'h17);
    wr(2'h1, 8'h07);
    pie_src_model_i.set_pins(1'b0, 1'b0);
    cyc(6);
    rd(2'h1, 8'h27);
  endtask

  initial begin
    reset = 1'b1;
    addr = 2'h0;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_access;
    t_events;
    t_edges;
    t_irq;
    conclude;
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    conclude;
  end
endmodule // testbench
`default_nettype wire
